//--- e1_monitor_consts.svh
/*
  Offsets, field positions, reset values and frame and slot positions for the E1
  timeslot monitor and signaling map block.
  Assumes an 8-bit host register port with 8-bit addresses.
*/
`ifndef E1_MONITOR_CONSTS_SVH
`define E1_MONITOR_CONSTS_SVH

`define ADDR_COMMON_CONTROL_FIVE 8'h1D
`define ADDR_SIG_CONTROL         8'h1F
`define ADDR_RX_SIG_FIRST        8'h30
`define ADDR_RX_SIG_LAST         8'h3F
`define ADDR_TX_SIG_FIRST        8'h40
`define ADDR_TX_SIG_LAST         8'h4F
`define ADDR_TIMESLOT_MONITOR    8'hAB

`define CHAN_SEL_MSB             4
`define CHAN_SEL_LSB             0
`define SIG_CTRL_INSERT_BIT      0
`define SIG_CTRL_PIN_SRC_BIT     1

`define RESET_BYTE               8'h00
`define UNMAPPED_READ            8'h00
`define SIG_TIMESLOT             5'h10
`define LAST_BIT_OF_SLOT         3'h7
`define FIRST_FRAME_BIT          8'h00

`endif

//--- e1_monitor_pkg.sv
/*
  Types shared by the E1 timeslot monitor and signaling map block.
  Assumes nothing beyond the consts header.
*/
`default_nettype none
package e1_monitor_pkg;

  // One bit of an E1 stream as delivered by the framing logic.
  typedef struct packed {
    logic dat;
    logic stb;
    logic fstart;
    logic mfstart;
  } e1_bit_t;

  // Host register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } host_req_t;

endpackage

`default_nettype wire

//--- e1_ds0_monitor_signaling_map.sv
/*
  Per-framer timeslot monitor and processor-based CAS signaling map.
  Assumes the framing logic, on clk, marks each line bit with a strobe and
  flags the first bit of every frame and of every CAS multiframe.
  The hardware signaling pin is asynchronous and is synchronised here.
*/
// Summary of operation
// RULE_01 - Five-bit channel select, bit 4 MSB, picks the monitored receive timeslot.
// RULE_02 - First received bit of the monitored timeslot lands in monitor bit 7.
// RULE_03 - Last received bit of the monitored timeslot lands in monitor bit 0.
// RULE_04 - Register and pin signaling access work at the same time; transmit inserts pin or registers, chosen by signaling control bit 1.
// RULE_05 - CAS bits are extracted from receive and inserted into transmit.
// RULE_06 - Four signaling bits A to D are carried per each of 30 voice channels.
// RULE_07 - Voice channel N is timeslot N for 1..15, timeslot N+1 for 16..30.
// RULE_08 - Sixteen receive and sixteen transmit signaling registers exist.
// RULE_09 - Receive signaling registers refresh each multiframe, always, two timeslots each.
// RULE_10 - Each multiframe, transmit signaling registers load the outgoing signaling shifter.
// RULE_11 - Monitor register is read-only and reloaded once per frame.
// RULE_12 - Selecting a channel beyond 32 timeslots gives undefined monitor contents.
`include "e1_monitor_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module e1_ds0_monitor_signaling_map
  import e1_monitor_pkg::*;
#(
  parameter int SIG_REGS = 16
) (
  // Clock, reset and enable.
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // Host register port.
  input  wire host_req_t  host,
  output logic [7:0]      rdata_r,
  // Receive stream from the framer.
  input  wire e1_bit_t    rx_in,
  // Transmit stream from the formatter and out to the line.
  input  wire e1_bit_t    tx_in,
  output logic            tx_out_r,
  output logic            tx_out_stb_r,
  // Hardware signaling access.
  input  wire logic       tx_sig_pin,
  output logic [7:0]      rx_sig_byte_r,
  output logic            rx_sig_stb_r
);

  logic [7:0] chan_ctrl_r, chan_ctrl_nxt;
  logic [7:0] sig_ctrl_r, sig_ctrl_nxt;
  logic [7:0] monitor_r, monitor_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] rx_sig_r [SIG_REGS];
  logic [7:0] rx_sig_nxt [SIG_REGS];
  logic [7:0] rx_stage_r [SIG_REGS];
  logic [7:0] rx_stage_nxt [SIG_REGS];
  logic [7:0] tx_sig_r [SIG_REGS];
  logic [7:0] tx_sig_nxt [SIG_REGS];
  logic [7:0] tx_shadow_r [SIG_REGS];
  logic [7:0] tx_shadow_nxt [SIG_REGS];
  logic [7:0] rx_pos_r, rx_pos_nxt, rx_pos;
  logic [3:0] rx_frm_r, rx_frm_nxt, rx_frm;
  logic [6:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] tx_pos_r, tx_pos_nxt, tx_pos;
  logic [3:0] tx_frm_r, tx_frm_nxt, tx_frm;
  logic       tx_out_nxt;
  logic       tx_out_stb_nxt;
  logic [7:0] rx_sig_byte_nxt;
  logic       rx_sig_stb_nxt;
  logic [2:0] pin_sync_r, pin_sync_nxt;
  logic       pin_val_r, pin_val_nxt;
  logic [7:0] rx_byte;
  logic [4:0] chan_sel;

  assign chan_sel = chan_ctrl_r[`CHAN_SEL_MSB:`CHAN_SEL_LSB]; // [RULE_01]
  // Position within the frame and frame within the multiframe for this bit.
  assign rx_pos  = rx_in.fstart ? `FIRST_FRAME_BIT : rx_pos_r + 8'h01;
  assign rx_frm  = rx_in.mfstart ? 4'h0 : (rx_in.fstart ? rx_frm_r + 4'h1 : rx_frm_r);
  assign tx_pos  = tx_in.fstart ? `FIRST_FRAME_BIT : tx_pos_r + 8'h01;
  assign tx_frm  = tx_in.mfstart ? 4'h0 : (tx_in.fstart ? tx_frm_r + 4'h1 : tx_frm_r);
  // Earlier bits sit higher, so the first bit of the slot ends up in bit 7.
  assign rx_byte = {rx_sh_r, rx_in.dat}; // [RULE_02] [RULE_03]

  // Receive path: timeslot monitor and CAS extraction.
  always_comb begin
    rx_pos_nxt      = rx_pos_r;
    rx_frm_nxt      = rx_frm_r;
    rx_sh_nxt       = rx_sh_r;
    monitor_nxt     = monitor_r;
    rx_sig_byte_nxt = rx_sig_byte_r;
    rx_sig_stb_nxt  = 1'b0;
    rx_stage_nxt    = rx_stage_r;
    rx_sig_nxt      = rx_sig_r;
    if (rx_in.stb) begin
      rx_pos_nxt = rx_pos;
      rx_frm_nxt = rx_frm;
      rx_sh_nxt  = rx_byte[6:0];
      if (rx_pos[2:0] == `LAST_BIT_OF_SLOT) begin
        // Every selector value names one of the 32 slots; software owns validity.
        if (rx_pos[7:3] == chan_sel) begin
          monitor_nxt = rx_byte; // [RULE_11] [RULE_12]
        end
        if (rx_pos[7:3] == `SIG_TIMESLOT) begin
          // Frame f carries voice channel f in the high nibble (timeslot f) and
          // voice channel f+15 in the low nibble (timeslot f+16).
          rx_stage_nxt[rx_frm] = rx_byte; // [RULE_05] [RULE_06] [RULE_07]
          rx_sig_byte_nxt      = rx_byte; // [RULE_04]
          rx_sig_stb_nxt       = 1'b1;
        end
      end
      if (rx_in.mfstart) begin
        rx_sig_nxt = rx_stage_r; // [RULE_09]
      end
    end
  end

  // Asynchronous signaling pin: a change counts once stages two and three agree.
  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], tx_sig_pin};
    pin_val_nxt  = (pin_sync_r[2] == pin_sync_r[1]) ? pin_sync_r[2] : pin_val_r;
  end

  // Transmit path: CAS insertion into timeslot 16.
  always_comb begin
    tx_pos_nxt     = tx_pos_r;
    tx_frm_nxt     = tx_frm_r;
    tx_out_nxt     = tx_out_r;
    tx_out_stb_nxt = 1'b0;
    tx_shadow_nxt  = tx_shadow_r;
    if (tx_in.stb) begin
      tx_pos_nxt     = tx_pos;
      tx_frm_nxt     = tx_frm;
      tx_out_stb_nxt = 1'b1;
      tx_out_nxt     = tx_in.dat;
      if (tx_in.mfstart) begin
        tx_shadow_nxt = tx_sig_r; // [RULE_10]
      end
      if (tx_pos[7:3] == `SIG_TIMESLOT && sig_ctrl_r[`SIG_CTRL_INSERT_BIT]) begin
        if (sig_ctrl_r[`SIG_CTRL_PIN_SRC_BIT]) begin
          tx_out_nxt = pin_val_r; // [RULE_04]
        end else begin
          tx_out_nxt = tx_shadow_r[tx_frm][`LAST_BIT_OF_SLOT - tx_pos[2:0]]; // [RULE_05] [RULE_07]
        end
      end
    end
  end

  // Host register port.
  always_comb begin
    chan_ctrl_nxt = chan_ctrl_r;
    sig_ctrl_nxt  = sig_ctrl_r;
    tx_sig_nxt    = tx_sig_r;
    rdata_nxt     = rdata_r;
    if (host.wr) begin
      if (host.addr == `ADDR_COMMON_CONTROL_FIVE) begin
        chan_ctrl_nxt = host.wdata;
      end
      if (host.addr == `ADDR_SIG_CONTROL) begin
        sig_ctrl_nxt = host.wdata;
      end
      if (host.addr >= `ADDR_TX_SIG_FIRST && host.addr <= `ADDR_TX_SIG_LAST) begin
        tx_sig_nxt[host.addr[3:0]] = host.wdata; // [RULE_08]
      end
    end
    if (host.rd) begin
      rdata_nxt = `UNMAPPED_READ;
      if (host.addr == `ADDR_COMMON_CONTROL_FIVE) begin
        rdata_nxt = chan_ctrl_r;
      end
      if (host.addr == `ADDR_SIG_CONTROL) begin
        rdata_nxt = sig_ctrl_r;
      end
      if (host.addr == `ADDR_TIMESLOT_MONITOR) begin
        rdata_nxt = monitor_r; // [RULE_11]
      end
      if (host.addr >= `ADDR_RX_SIG_FIRST && host.addr <= `ADDR_RX_SIG_LAST) begin
        rdata_nxt = rx_sig_r[host.addr[3:0]]; // [RULE_08]
      end
      if (host.addr >= `ADDR_TX_SIG_FIRST && host.addr <= `ADDR_TX_SIG_LAST) begin
        rdata_nxt = tx_sig_r[host.addr[3:0]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      chan_ctrl_r   <= `RESET_BYTE;
      sig_ctrl_r    <= `RESET_BYTE;
      monitor_r     <= `RESET_BYTE;
      rdata_r       <= `RESET_BYTE;
      rx_pos_r      <= `FIRST_FRAME_BIT;
      rx_frm_r      <= 4'h0;
      rx_sh_r       <= 7'h00;
      tx_pos_r      <= `FIRST_FRAME_BIT;
      tx_frm_r      <= 4'h0;
      tx_out_r      <= 1'b0;
      tx_out_stb_r  <= 1'b0;
      rx_sig_byte_r <= `RESET_BYTE;
      rx_sig_stb_r  <= 1'b0;
      pin_sync_r    <= 3'h0;
      pin_val_r     <= 1'b0;
      for (int i = 0; i < SIG_REGS; i++) begin
        rx_sig_r[i]    <= `RESET_BYTE;
        rx_stage_r[i]  <= `RESET_BYTE;
        tx_sig_r[i]    <= `RESET_BYTE;
        tx_shadow_r[i] <= `RESET_BYTE;
      end
    end else if (ce) begin
      chan_ctrl_r   <= chan_ctrl_nxt;
      sig_ctrl_r    <= sig_ctrl_nxt;
      monitor_r     <= monitor_nxt;
      rdata_r       <= rdata_nxt;
      rx_pos_r      <= rx_pos_nxt;
      rx_frm_r      <= rx_frm_nxt;
      rx_sh_r       <= rx_sh_nxt;
      tx_pos_r      <= tx_pos_nxt;
      tx_frm_r      <= tx_frm_nxt;
      tx_out_r      <= tx_out_nxt;
      tx_out_stb_r  <= tx_out_stb_nxt;
      rx_sig_byte_r <= rx_sig_byte_nxt;
      rx_sig_stb_r  <= rx_sig_stb_nxt;
      pin_sync_r    <= pin_sync_nxt;
      pin_val_r     <= pin_val_nxt;
      rx_sig_r      <= rx_sig_nxt;
      rx_stage_r    <= rx_stage_nxt;
      tx_sig_r      <= tx_sig_nxt;
      tx_shadow_r   <= tx_shadow_nxt;
    end
  end

endmodule

`default_nettype wire

//--- e1_mon_chk_properties.sv
/* Port checker for the timeslot monitor block.
   Assumes it is bound onto the block and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module e1_mon_chk
  import e1_monitor_pkg::*;
(
  // Clock and control.
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       ce,
  // Host port and streams.
  input wire host_req_t  host,
  input wire logic [7:0] rdata_r,
  input wire e1_bit_t    rx_in,
  input wire e1_bit_t    tx_in,
  input wire logic       tx_out_r,
  input wire logic       tx_out_stb_r,
  input wire logic [7:0] rx_sig_byte_r,
  input wire logic       rx_sig_stb_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence slot_s;
    (ce && rx_in.stb) [*8] ##1 rx_sig_stb_r;
  endsequence
  AST_TX_STB: assert property (ce && tx_in.stb |=> tx_out_stb_r) else $error("tx strobe late");
  AST_FREEZE: assert property (!ce |=> $stable(tx_out_stb_r) && $stable(rx_sig_byte_r)) else $error("freeze");
  AST_TX_HOLD: assert property (!(ce && tx_in.stb) |=> $stable(tx_out_r)) else $error("tx bit moved");
  AST_RD_HOLD: assert property (!(ce && host.rd) |=> $stable(rdata_r)) else $error("read data moved");
  AST_RD_UNMAP: assert property (ce && host.rd && host.addr == 8'h80 |=> rdata_r == 8'h00) else $error("unmapped");
  AST_SIG_PULSE: assert property (rx_sig_stb_r && ce |=> !rx_sig_stb_r) else $error("sig strobe long");
  AST_SIG_CAUSE: assert property ($rose(rx_sig_stb_r) |-> $past(ce) && $past(rx_in.stb)) else $error("sig cause");
  AST_SIG_ORDER: assert property (slot_s |-> rx_sig_byte_r[7] == $past(rx_in.dat, 8) &&
    rx_sig_byte_r[0] == $past(rx_in.dat)) else $error("sig bit order");
endmodule
bind e1_ds0_monitor_signaling_map e1_mon_chk chk (.clk(clk), .rstn(rstn), .ce(ce), .host(host), .rdata_r(rdata_r),
  .rx_in(rx_in), .tx_in(tx_in), .tx_out_r(tx_out_r), .tx_out_stb_r(tx_out_stb_r),
  .rx_sig_byte_r(rx_sig_byte_r), .rx_sig_stb_r(rx_sig_stb_r));
`default_nettype wire

//--- e1_line_model.sv
/* Line model feeding both streams of the block with framed bits.
   Assumes a free clock; a bit advances only after the block took it. */
`timescale 1ns/1ps
`default_nettype none
module e1_line_model
  import e1_monitor_pkg::*;
(
  // Clock and freeze.
  input  wire logic    clk,
  input  wire logic    ce,
  // Streams into the block.
  output wire e1_bit_t rx,
  output wire e1_bit_t tx
);
  logic [11:0] cnt_r  = 12'h000;
  logic        took_r = 1'b0;
  // Each slot carries its own number, so selection and bit order errors show.
  wire logic [7:0] pat = {cnt_r[7:3], 3'h3};
  always @(posedge clk) took_r <= ce;
  always @(negedge clk) if (took_r) cnt_r <= cnt_r + 12'h001;
  assign rx = '{dat: pat[3'h7 - cnt_r[2:0]], stb: 1'b1, fstart: cnt_r[7:0] == 8'h00, mfstart: cnt_r == 12'h000};
  assign tx = rx;
endmodule
`default_nettype wire

//--- e1_ds0_monitor_signaling_map_tb_top.sv
/* Testbench for the timeslot monitor block.
   Assumes the line model drives both streams. */
`timescale 1ns/1ps
`default_nettype none
module e1_ds0_monitor_signaling_map_tb_top
  import e1_monitor_pkg::*;
;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ce = 1'b1;
  host_req_t  host = '0;
  logic [7:0] rdata_r, rx_sig_byte_r;
  logic       tx_out_r, tx_out_stb_r, rx_sig_stb_r;
  e1_bit_t    rx_in, tx_in;
  int         error_cnt = 0;
  int         total_checks = 0;
  logic       sig_pin = 1'b0;
  logic [7:0] tx_byte;
  logic [4:0] slots [4] = '{5'h00, 5'h05, 5'h10, 5'h1F};
  initial forever #20 clk = ~clk;
  e1_line_model line (.clk(clk), .ce(ce), .rx(rx_in), .tx(tx_in));
  e1_ds0_monitor_signaling_map DUT (.clk(clk), .rstn(rstn), .ce(ce), .host(host), .rdata_r(rdata_r),
    .rx_in(rx_in), .tx_in(tx_in), .tx_out_r(tx_out_r), .tx_out_stb_r(tx_out_stb_r),
    .tx_sig_pin(sig_pin), .rx_sig_byte_r(rx_sig_byte_r), .rx_sig_stb_r(rx_sig_stb_r));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host = '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge clk);
    host = '0;
  endtask
  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    check(rdata_r, exp);
  endtask
  // Finds a multiframe start on the transmit stream, skips some bits and collects eight sent bits, first one high.
  task automatic tx_grab(input int skip, output logic [7:0] got);
    int n;
    n = 0;
    got = 8'h00;
    do begin
      @(posedge clk);
      n++;
    end while (!tx_in.mfstart && n < 5000);
    if (n >= 5000) begin
      error_cnt++;
      give_verdict();
    end
    repeat (skip) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      got = {got[6:0], tx_out_r};
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    read_chk(8'hAB, 8'h00);
    foreach (slots[i]) begin
      access(1'b1, 8'h1D, {3'h5, slots[i]});
      repeat (300) @(negedge clk);
      read_chk(8'hAB, {slots[i], 3'h3});
      read_chk(8'h1D, {3'h5, slots[i]});
    end
    access(1'b1, 8'hAB, 8'h00);
    read_chk(8'hAB, 8'hFB);
    $display("monitor test done");
    repeat (8400) @(negedge clk);
    for (int i = 0; i < 16; i++) read_chk(8'h30 + i[7:0], 8'h83);
    access(1'b1, 8'h31, 8'h00);
    read_chk(8'h31, 8'h83);
    for (int i = 0; i < 16; i++) begin
      access(1'b1, 8'h40 + i[7:0], {i[3:0], ~i[3:0]});
      read_chk(8'h40 + i[7:0], {i[3:0], ~i[3:0]});
    end
    $display("signaling test done");
    tx_grab(384, tx_byte);
    check(tx_byte, 8'h83);
    access(1'b1, 8'h1F, 8'h01);
    tx_grab(384, tx_byte);
    check(tx_byte, 8'h1E);
    check({7'h00, tx_out_stb_r}, 8'h01);
    sig_pin = 1'b1;
    access(1'b1, 8'h1F, 8'h03);
    tx_grab(384, tx_byte);
    check(tx_byte, 8'hFF);
    $display("transmit test done");
    ce = 1'b0;
    access(1'b0, 8'h80, 8'h00);
    check(rdata_r, 8'hF0);
    ce = 1'b1;
    read_chk(8'h80, 8'h00);
    repeat (300) @(negedge clk);
    check(rx_sig_byte_r, 8'h83);
    $display("freeze test done");
    give_verdict();
  end
endmodule
`default_nettype wire
